// *** src/cibcc_pkg.sv ***
// Constants and types shared by the interrupt and bus cycle controller
package cibcc_pkg;
    // Timing
    localparam int unsigned CLK_HZ      = 125000000;
    localparam int unsigned XTAL_MIN_HZ = 1000000;
    localparam int unsigned TSTATE_DIV  = 2;
    // Register offsets
    localparam logic [2:0] REG_SETMASK  = 3'h0;
    localparam logic [2:0] REG_READMASK = 3'h1;
    localparam logic [2:0] REG_CONTROL  = 3'h2;
    localparam logic [2:0] REG_VECTOR   = 3'h3;
    localparam logic [2:0] REG_CYC_ADDR = 3'h4;
    localparam logic [2:0] REG_CYC_DATA = 3'h5;
    localparam logic [2:0] REG_CYC_GO   = 3'h6;
    localparam logic [2:0] REG_STATUS   = 3'h7;
    // Set-mask fields
    localparam int SM_MSE = 3;
    localparam int SM_R75 = 4;
    localparam int SM_SOE = 6;
    localparam int SM_SOD = 7;
    // Read-mask fields
    localparam int RM_IE   = 3;
    localparam int RM_PEND = 4;
    localparam int RM_SID  = 7;
    // Control fields
    localparam int CT_EI  = 0;
    localparam int CT_DI  = 1;
    localparam int CT_ACK = 2;
    // Cycle start fields
    localparam int CG_TYPE  = 0;
    localparam int CG_LONG  = 3;
    localparam int CG_NOALE = 4;
    localparam int CG_HALT  = 5;
    // Status fields
    localparam int SR_BUSY = 0;
    localparam int SR_HALT = 1;
    localparam int SR_HLDA = 2;
    localparam int SR_IREQ = 3;
    localparam int SR_SRC  = 4;
    // Reset values
    localparam logic [2:0] MASK_RST = 3'h7;
    localparam logic       IE_RST   = 1'h0;
    // Interrupt sources
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_TRAP = 3'h1;
    localparam logic [2:0] SRC_R75  = 3'h2;
    localparam logic [2:0] SRC_R65  = 3'h3;
    localparam logic [2:0] SRC_R55  = 3'h4;
    localparam logic [2:0] SRC_GENERAL_INTERRUPT_INPUT = 3'h5;
    // Restart vectors
    localparam logic [7:0] VEC_TRAP = 8'h24;
    localparam logic [7:0] VEC_R75  = 8'h3C;
    localparam logic [7:0] VEC_R65  = 8'h34;
    localparam logic [7:0] VEC_R55  = 8'h2C;
    localparam logic [7:0] VEC_GENERAL_INTERRUPT_INPUT = 8'h00;
    // Machine cycle types
    localparam logic [2:0] CY_OF  = 3'h0;
    localparam logic [2:0] CY_MR  = 3'h1;
    localparam logic [2:0] CY_MW  = 3'h2;
    localparam logic [2:0] CY_IOR = 3'h3;
    localparam logic [2:0] CY_IOW = 3'h4;
    localparam logic [2:0] CY_INA = 3'h5;
    localparam logic [2:0] CY_BI  = 3'h6;
    // Synchroniser lanes
    localparam int SY_TRAP = 0;
    localparam int SY_R75  = 1;
    localparam int SY_R65  = 2;
    localparam int SY_R55  = 3;
    localparam int SY_GENERAL_INTERRUPT_INPUT = 4;
    localparam int SY_HOLD = 5;
    localparam int SY_RDY  = 6;
    localparam int SY_SID  = 7;

    typedef enum logic [9:0] {
        TS_IDLE = 10'h001,
        TS_T1   = 10'h002,
        TS_T2   = 10'h004,
        TS_TW   = 10'h008,
        TS_T3   = 10'h010,
        TS_T4   = 10'h020,
        TS_T5   = 10'h040,
        TS_T6   = 10'h080,
        TS_HALT = 10'h100,
        TS_HOLD = 10'h200
    } cibcc_tstate_t;
endpackage

// *** src/cibcc_top.sv ***
// Interrupt front end and machine cycle sequencer
// Functional notes
// - Five interrupt inputs, three restart masks
// - Maskable taken only if enabled, unmasked
// - Nonmaskable ignores enable and masks
// - 5.5 and 6.5 are level sensitive
// - 7.5 edge latched until serviced
// - 7.5 latch cleared by set-mask, reset
// - 7.5 edge latched even when masked
// - Fixed priority trap, 7.5, 6.5, 5.5, general
// - Priority ignores running service routine
// - Trap needs edge and level, rearms low
// - Servicing any interrupt clears global enable
// - First read-mask after trap shows saved enable
// - Read-mask after maskable shows disabled
// - Read-mask samples input, set-mask drives output
// - Serial input lands in bit 7
// - Vectors 24, 3C, 34, 2C hex
// - All interrupts and hold are synchronised
// - T states run at input clock halved
// - Seven cycle types with status, strobes on all but bus idle
// - Status at T1, strobes later
// - Three states, fetch four or six, waits
// - I/O port address on both halves
// - Address strobe only T1, not double-add
module cibcc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [2:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        trap_i,
    input  wire logic        rst75_i,
    input  wire logic        rst65_i,
    input  wire logic        rst55_i,
    input  wire logic        general_interrupt_input_i,
    input  wire logic        hold_req_i,
    input  wire logic        ready_i,
    input  wire logic        serial_input_line_i,
    input  wire logic [7:0]  ad_i,
    output logic             clk_out_o,
    output logic             int_req_o,
    output logic      [7:0]  int_vector_o,
    output logic             serial_output_line_o,
    output logic             ale_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic             acknowledge_strobe_n_o,
    output logic             cycle_status_high_o,
    output logic             cycle_status_low_o,
    output logic             io_or_mem_o,
    output logic      [7:0]  addr_hi_o,
    output logic      [7:0]  ad_o,
    output logic             addr_oe_o,
    output logic             ad_oe_o,
    output logic             ctl_oe_o,
    output logic             hold_ack_o
);

    typedef struct packed {
        logic [7:0]                 sy1;
        logic [7:0]                 sy2;
        logic [7:0]                 ad1;
        logic [7:0]                 ad2;
        logic                       r75_prev;
        logic                       trap_prev;
        logic                       r75_ff;
        logic                       trap_ff;
        logic                       ie;
        logic                       trap_flag;
        logic                       saved_ie;
        logic [2:0]                 mask;
        logic                       serial_output_line;
        logic                       phase;
        cibcc_pkg::cibcc_tstate_t   st;
        logic                       go;
        logic                       halt_go;
        logic [2:0]                 cyc;
        logic                       lng;
        logic                       noale;
        logic [15:0]                addr;
        logic [7:0]                 wdat;
        logic [7:0]                 rdat;
        logic [15:0]                rdout;
        logic                       int_req;
        logic [2:0]                 src;
        logic [7:0]                 vec;
        logic                       ale;
        logic                       rd_n;
        logic                       wr_n;
        logic                       ack_n;
        logic                       s1;
        logic                       s0;
        logic                       iom;
        logic [7:0]                 a_hi;
        logic [7:0]                 ad;
        logic                       a_oe;
        logic                       ad_oe;
        logic                       c_oe;
        logic                       hlda;
    } cibcc_regs_t;

    cibcc_regs_t r;
    cibcc_regs_t n;

    // {io_or_mem, status_high, status_low} of a cycle type
    function automatic logic [2:0] cyc_status(input logic [2:0] cy);
        unique case (cy)
            cibcc_pkg::CY_OF:  cyc_status = 3'h3;
            cibcc_pkg::CY_MR:  cyc_status = 3'h2;
            cibcc_pkg::CY_MW:  cyc_status = 3'h1;
            cibcc_pkg::CY_IOR: cyc_status = 3'h6;
            cibcc_pkg::CY_IOW: cyc_status = 3'h5;
            cibcc_pkg::CY_INA: cyc_status = 3'h7;
            default:           cyc_status = 3'h2;
        endcase
    endfunction

    // Active-high {read, write, acknowledge} strobe of a cycle type
    function automatic logic [2:0] cyc_strobe(input logic [2:0] cy);
        unique case (cy)
            cibcc_pkg::CY_OF,
            cibcc_pkg::CY_MR,
            cibcc_pkg::CY_IOR: cyc_strobe = 3'h4;
            cibcc_pkg::CY_MW,
            cibcc_pkg::CY_IOW: cyc_strobe = 3'h2;
            cibcc_pkg::CY_INA: cyc_strobe = 3'h1;
            default:           cyc_strobe = 3'h0;
        endcase
    endfunction

    function automatic logic cyc_is_io(input logic [2:0] cy);
        cyc_is_io = (cy == cibcc_pkg::CY_IOR) || (cy == cibcc_pkg::CY_IOW);
    endfunction

    logic       rise75;
    logic       rise_trap;
    logic       trap_req;
    logic       req75;
    logic       req65;
    logic       req55;
    logic       reqi;
    logic [2:0] src;
    logic [7:0] vec;
    logic       wr_sm;
    logic       wr_ct;
    logic       ack;
    logic       clr75;
    logic       tick;
    logic       cyc_end;
    logic [2:0] stat;
    logic [2:0] strb;

    always_comb
    begin
        n = r;
        // Only the second stage is read by logic
        n.sy1 = {serial_input_line_i, ready_i, hold_req_i, general_interrupt_input_i,
                 rst55_i, rst65_i, rst75_i, trap_i};
        n.sy2 = r.sy1;
        n.ad1 = ad_i;
        n.ad2 = r.ad1;
        n.r75_prev = r.sy2[cibcc_pkg::SY_R75];
        n.trap_prev = r.sy2[cibcc_pkg::SY_TRAP];
        rise75 = r.sy2[cibcc_pkg::SY_R75] & ~r.r75_prev;
        rise_trap = r.sy2[cibcc_pkg::SY_TRAP] & ~r.trap_prev;

        // Request qualification
        trap_req = r.trap_ff & r.sy2[cibcc_pkg::SY_TRAP];
        req75 = r.r75_ff & ~r.mask[2] & r.ie;
        req65 = r.sy2[cibcc_pkg::SY_R65] & ~r.mask[1] & r.ie;
        req55 = r.sy2[cibcc_pkg::SY_R55] & ~r.mask[0] & r.ie;
        reqi = r.sy2[cibcc_pkg::SY_GENERAL_INTERRUPT_INPUT] & r.ie;
        // No record of the running routine is kept
        if (trap_req)
        begin
            src = cibcc_pkg::SRC_TRAP;
            vec = cibcc_pkg::VEC_TRAP;
        end
        else if (req75)
        begin
            src = cibcc_pkg::SRC_R75;
            vec = cibcc_pkg::VEC_R75;
        end
        else if (req65)
        begin
            src = cibcc_pkg::SRC_R65;
            vec = cibcc_pkg::VEC_R65;
        end
        else if (req55)
        begin
            src = cibcc_pkg::SRC_R55;
            vec = cibcc_pkg::VEC_R55;
        end
        else if (reqi)
        begin
            src = cibcc_pkg::SRC_GENERAL_INTERRUPT_INPUT;
            vec = cibcc_pkg::VEC_GENERAL_INTERRUPT_INPUT;
        end
        else
        begin
            src = cibcc_pkg::SRC_NONE;
            vec = cibcc_pkg::VEC_GENERAL_INTERRUPT_INPUT;
        end
        n.src = src;
        n.vec = vec;
        n.int_req = (src != cibcc_pkg::SRC_NONE);

        // Register writes
        wr_sm = reg_wr_i && (reg_addr_i == cibcc_pkg::REG_SETMASK);
        wr_ct = reg_wr_i && (reg_addr_i == cibcc_pkg::REG_CONTROL);
        ack = wr_ct && reg_wdata_i[cibcc_pkg::CT_ACK] && (src != cibcc_pkg::SRC_NONE);
        clr75 = 1'b0;
        if (wr_sm)
        begin
            if (reg_wdata_i[cibcc_pkg::SM_MSE])
            begin
                n.mask = reg_wdata_i[2:0];
            end
            if (reg_wdata_i[cibcc_pkg::SM_R75])
            begin
                clr75 = 1'b1;
            end
            if (reg_wdata_i[cibcc_pkg::SM_SOE])
            begin
                n.serial_output_line = reg_wdata_i[cibcc_pkg::SM_SOD];
            end
        end
        if (wr_ct && reg_wdata_i[cibcc_pkg::CT_EI])
        begin
            n.ie = 1'b1;
        end
        if (wr_ct && reg_wdata_i[cibcc_pkg::CT_DI])
        begin
            n.ie = 1'b0;
        end
        if (ack)
        begin
            // Acknowledge overrides an enable in the same write
            n.ie = 1'b0;
            if (src == cibcc_pkg::SRC_TRAP)
            begin
                n.saved_ie = r.ie;
                n.trap_flag = 1'b1;
            end
            else
            begin
                n.trap_flag = 1'b0;
            end
            if (src == cibcc_pkg::SRC_R75)
            begin
                clr75 = 1'b1;
            end
        end
        // A new edge beats a clear in the same cycle, mask or not
        n.r75_ff = rise75 | (r.r75_ff & ~clr75);
        // Rearms only after the synced level fell and rose again
        n.trap_ff = rise_trap | (r.trap_ff & ~(ack && src == cibcc_pkg::SRC_TRAP));

        // Register reads: data stands one cycle only
        n.rdout = 16'h0000;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                cibcc_pkg::REG_SETMASK:
                    n.rdout = {13'h0000, r.mask};
                cibcc_pkg::REG_READMASK:
                begin
                    n.rdout[2:0] = r.mask;
                    n.rdout[cibcc_pkg::RM_IE] = r.trap_flag ? r.saved_ie : r.ie;
                    n.rdout[cibcc_pkg::RM_PEND +: 3] = {r.r75_ff, r.sy2[cibcc_pkg::SY_R65],
                                                        r.sy2[cibcc_pkg::SY_R55]};
                    n.rdout[cibcc_pkg::RM_SID] = r.sy2[cibcc_pkg::SY_SID];
                    n.trap_flag = 1'b0;
                end
                cibcc_pkg::REG_CONTROL:
                    n.rdout = {15'h0000, r.ie};
                cibcc_pkg::REG_VECTOR:
                    n.rdout = {8'h00, r.vec};
                cibcc_pkg::REG_CYC_ADDR:
                    n.rdout = r.addr;
                cibcc_pkg::REG_CYC_DATA:
                    n.rdout = {8'h00, r.rdat};
                cibcc_pkg::REG_CYC_GO:
                    n.rdout = {10'h000, r.halt_go, r.noale, r.lng, r.cyc};
                cibcc_pkg::REG_STATUS:
                begin
                    n.rdout[cibcc_pkg::SR_BUSY] = r.go | (r.st != cibcc_pkg::TS_IDLE);
                    n.rdout[cibcc_pkg::SR_HALT] = (r.st == cibcc_pkg::TS_HALT);
                    n.rdout[cibcc_pkg::SR_HLDA] = r.hlda;
                    n.rdout[cibcc_pkg::SR_IREQ] = r.int_req;
                    n.rdout[cibcc_pkg::SR_SRC +: 3] = r.src;
                end
            endcase
        end

        // Cycle set-up, ignored while a cycle runs
        if (reg_wr_i && !r.go && r.st == cibcc_pkg::TS_IDLE)
        begin
            if (reg_addr_i == cibcc_pkg::REG_CYC_ADDR)
            begin
                n.addr = reg_wdata_i;
            end
            if (reg_addr_i == cibcc_pkg::REG_CYC_DATA)
            begin
                n.wdat = reg_wdata_i[7:0];
            end
            if (reg_addr_i == cibcc_pkg::REG_CYC_GO)
            begin
                n.cyc = reg_wdata_i[cibcc_pkg::CG_TYPE +: 3];
                n.lng = reg_wdata_i[cibcc_pkg::CG_LONG];
                n.noale = reg_wdata_i[cibcc_pkg::CG_NOALE];
                n.halt_go = reg_wdata_i[cibcc_pkg::CG_HALT];
                n.go = 1'b1;
            end
        end

        // T states advance on every second clock
        n.phase = ~r.phase;
        tick = r.phase;
        cyc_end = 1'b0;
        if (tick)
        begin
            unique case (r.st)
                cibcc_pkg::TS_IDLE:
                    if (r.sy2[cibcc_pkg::SY_HOLD])
                    begin
                        n.st = cibcc_pkg::TS_HOLD;
                    end
                    else if (r.go)
                    begin
                        n.go = 1'b0;
                        n.st = r.halt_go ? cibcc_pkg::TS_HALT : cibcc_pkg::TS_T1;
                    end
                cibcc_pkg::TS_T1:
                    n.st = cibcc_pkg::TS_T2;
                cibcc_pkg::TS_T2,
                cibcc_pkg::TS_TW:
                    // Bus idle cycles take no wait states
                    if (r.sy2[cibcc_pkg::SY_RDY] || r.cyc == cibcc_pkg::CY_BI)
                    begin
                        n.st = cibcc_pkg::TS_T3;
                    end
                    else
                    begin
                        n.st = cibcc_pkg::TS_TW;
                    end
                cibcc_pkg::TS_T3:
                begin
                    if (cyc_strobe(r.cyc) != 3'h2)
                    begin
                        n.rdat = r.ad2;
                    end
                    if (r.cyc == cibcc_pkg::CY_OF)
                    begin
                        n.st = cibcc_pkg::TS_T4;
                    end
                    else
                    begin
                        cyc_end = 1'b1;
                    end
                end
                cibcc_pkg::TS_T4:
                    if (r.lng)
                    begin
                        n.st = cibcc_pkg::TS_T5;
                    end
                    else
                    begin
                        cyc_end = 1'b1;
                    end
                cibcc_pkg::TS_T5:
                    n.st = cibcc_pkg::TS_T6;
                cibcc_pkg::TS_T6:
                    cyc_end = 1'b1;
                cibcc_pkg::TS_HALT:
                    if (r.int_req)
                    begin
                        n.st = cibcc_pkg::TS_IDLE;
                    end
                cibcc_pkg::TS_HOLD:
                    if (!r.sy2[cibcc_pkg::SY_HOLD])
                    begin
                        n.st = cibcc_pkg::TS_IDLE;
                    end
            endcase
            if (cyc_end)
            begin
                n.st = r.sy2[cibcc_pkg::SY_HOLD] ? cibcc_pkg::TS_HOLD : cibcc_pkg::TS_IDLE;
            end
        end

        // Pin levels follow the next T state so they leave flops
        stat = cyc_status(n.cyc);
        strb = cyc_strobe(n.cyc);
        n.ale = 1'b0;
        n.rd_n = 1'b1;
        n.wr_n = 1'b1;
        n.ack_n = 1'b1;
        n.a_oe = 1'b0;
        n.ad_oe = 1'b0;
        n.c_oe = 1'b0;
        n.hlda = 1'b0;
        unique case (n.st)
            cibcc_pkg::TS_T1:
            begin
                {n.iom, n.s1, n.s0} = stat;
                n.ale = ~n.noale;
                n.c_oe = 1'b1;
                n.a_oe = 1'b1;
                n.ad_oe = 1'b1;
                n.a_hi = cyc_is_io(n.cyc) ? n.addr[7:0] : n.addr[15:8];
                n.ad = n.addr[7:0];
            end
            cibcc_pkg::TS_T2,
            cibcc_pkg::TS_TW,
            cibcc_pkg::TS_T3:
            begin
                {n.iom, n.s1, n.s0} = stat;
                {n.rd_n, n.wr_n, n.ack_n} = ~strb;
                n.c_oe = 1'b1;
                n.a_oe = 1'b1;
                n.ad_oe = (strb == 3'h2);
                n.ad = n.wdat;
            end
            cibcc_pkg::TS_T4,
            cibcc_pkg::TS_T5,
            cibcc_pkg::TS_T6:
            begin
                n.iom = (n.cyc == cibcc_pkg::CY_INA);
                n.s1 = 1'b1;
                n.s0 = 1'b1;
                n.c_oe = 1'b1;
                n.a_oe = 1'b1;
            end
            cibcc_pkg::TS_HALT:
            begin
                n.s1 = 1'b0;
                n.s0 = 1'b0;
            end
            cibcc_pkg::TS_HOLD:
                n.hlda = 1'b1;
            cibcc_pkg::TS_IDLE:
                n.ale = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            // Bus lines float and 7.5 latch clears under reset
            r <= '0;
            r.st <= cibcc_pkg::TS_IDLE;
            r.mask <= cibcc_pkg::MASK_RST;
            r.ie <= cibcc_pkg::IE_RST;
            r.rd_n <= 1'b1;
            r.wr_n <= 1'b1;
            r.ack_n <= 1'b1;
        end
        else if (ce_i)
        begin
            r <= n;
        end
    end

    assign reg_rdata_o = r.rdout;
    assign clk_out_o = r.phase;
    assign int_req_o = r.int_req;
    assign int_vector_o = r.vec;
    assign serial_output_line_o = r.serial_output_line;
    assign ale_o = r.ale;
    assign rd_n_o = r.rd_n;
    assign wr_n_o = r.wr_n;
    assign acknowledge_strobe_n_o = r.ack_n;
    assign cycle_status_high_o = r.s1;
    assign cycle_status_low_o = r.s0;
    assign io_or_mem_o = r.iom;
    assign addr_hi_o = r.a_hi;
    assign ad_o = r.ad;
    assign addr_oe_o = r.a_oe;
    assign ad_oe_o = r.ad_oe;
    assign ctl_oe_o = r.c_oe;
    assign hold_ack_o = r.hlda;

endmodule // cibcc_top

// *** verif/cibcc_partner.sv ***
// Memory and port device on the multiplexed bus
module cibcc_partner (
    input  wire logic       clk_i,
    input  wire logic       rd_n_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] ad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] junk = 8'h5A;
    // Released bus shows the inverse so stale data never passes
    always @(posedge clk_i) junk <= rd_n_i ? ~data_i : data_i;
    assign ad_o = junk;
endmodule // cibcc_partner

// *** verif/cibcc_properties.sv ***
// Port-level checks of the bus cycle outputs
module cibcc_properties (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       clk_out_o,
    input wire logic       ale_o,
    input wire logic       rd_n_o,
    input wire logic       wr_n_o,
    input wire logic       acknowledge_strobe_n_o,
    input wire logic       cycle_status_high_o,
    input wire logic       cycle_status_low_o,
    input wire logic       io_or_mem_o,
    input wire logic [7:0] addr_hi_o,
    input wire logic [7:0] ad_o,
    input wire logic       addr_oe_o,
    input wire logic       ad_oe_o,
    input wire logic       ctl_oe_o,
    input wire logic       hold_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // One T state is two clocks
    sequence s_ale_pulse;
        ale_o ##1 ale_o ##1 !ale_o;
    endsequence
    sequence s_rd_span;
        !rd_n_o [*4] ##1 rd_n_o;
    endsequence
    clk_half_a: assert property (!$past(rst_i) |-> $changed(clk_out_o))
        else $error("clock output did not toggle");
    ale_width_a: assert property ($rose(ale_o) |-> s_ale_pulse)
        else $error("address strobe not one T state");
    strobe_late_a: assert property (ale_o |-> rd_n_o && wr_n_o && acknowledge_strobe_n_o)
        else $error("strobe active in first T state");
    rd_alone_a: assert property (!rd_n_o |-> wr_n_o && acknowledge_strobe_n_o)
        else $error("read strobe overlaps another strobe");
    ack_status_a: assert property (!acknowledge_strobe_n_o
        |-> io_or_mem_o && cycle_status_high_o && cycle_status_low_o)
        else $error("acknowledge strobe with wrong status");
    wr_status_a: assert property (!wr_n_o |-> !cycle_status_high_o && cycle_status_low_o)
        else $error("write strobe with wrong status");
    rd_span_a: assert property ($fell(rd_n_o) |-> s_rd_span)
        else $error("read strobe not two T states");
    io_copy_a: assert property (ale_o && io_or_mem_o && (cycle_status_high_o ^ cycle_status_low_o)
        |-> addr_hi_o == ad_o)
        else $error("port address not on both halves");
    hold_float_a: assert property (hold_ack_o
        |-> !(addr_oe_o || ad_oe_o || ctl_oe_o) && acknowledge_strobe_n_o)
        else $error("bus driven in hold");
endmodule // cibcc_properties

bind cibcc_top cibcc_properties u_props (.clk_i, .rst_i, .clk_out_o, .ale_o, .rd_n_o, .wr_n_o,
    .acknowledge_strobe_n_o, .cycle_status_high_o, .cycle_status_low_o, .io_or_mem_o,
    .addr_hi_o, .ad_o, .addr_oe_o, .ad_oe_o, .ctl_oe_o, .hold_ack_o);

// *** verif/cibcc_top_tb.sv ***
// Self-checking bench for the interrupt and bus cycle controller
module cibcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, wr = 0, rd = 0, hold = 0, serial_input_line = 0;
    logic        trap = 0, r75 = 0, r65 = 0, r55 = 0, gi = 0;
    logic [2:0]  a = 3'h0;
    logic [15:0] wd = 16'h0000, rdata;
    logic [7:0]  ad_i, vec;
    logic        irq, serial_output_line, rd_n, hack, aoe;
    int          errors = 0, n_checks = 0;
    always #4 clk_i = ~clk_i;
    cibcc_partner u_mem (.clk_i, .rd_n_i(rd_n), .data_i(8'hA5), .ad_o(ad_i));
    cibcc_top u_dut (.clk_i, .rst_i, .ce_i(1'b1), .reg_addr_i(a), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .trap_i(trap), .rst75_i(r75),
        .rst65_i(r65), .rst55_i(r55), .general_interrupt_input_i(gi), .hold_req_i(hold),
        .ready_i(1'b1), .serial_input_line_i(serial_input_line), .ad_i, .clk_out_o(), .int_req_o(irq),
        .int_vector_o(vec), .serial_output_line_o(serial_output_line), .ale_o(), .rd_n_o(rd_n), .wr_n_o(),
        .acknowledge_strobe_n_o(), .cycle_status_high_o(), .cycle_status_low_o(),
        .io_or_mem_o(), .addr_hi_o(), .ad_o(), .addr_oe_o(aoe), .ad_oe_o(), .ctl_oe_o(),
        .hold_ack_o(hack));
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr16(logic [2:0] ad, logic [15:0] d);
        @(posedge clk_i);
        a <= ad;
        wd <= d;
        wr <= 1;
        @(posedge clk_i);
        wr <= 0;
    endtask
    task automatic rd16(logic [2:0] ad, output logic [15:0] q);
        @(posedge clk_i);
        a <= ad;
        rd <= 1;
        @(posedge clk_i);
        rd <= 0;
        #1 q = rdata;
    endtask
    task automatic rdc(logic [2:0] ad, logic [15:0] e, string n);
        logic [15:0] q;
        rd16(ad, q);
        chk(n, e, q);
    endtask
    task automatic pins(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic t_serial;
        rdc(3'h1, 16'h0007, "mask after reset");
        serial_input_line <= 1;
        pins(4);
        rdc(3'h1, 16'h0087, "serial in");
        wr16(3'h0, 16'h00C0);
        pins(2);
        chk("serial out", 1, serial_output_line);
        serial_input_line <= 0;
    endtask
    task automatic t_latch;
        r75 <= 1;
        pins(4);
        r75 <= 0;
        pins(4);
        rdc(3'h1, 16'h0047, "masked latch");
        wr16(3'h0, 16'h0010);
        rdc(3'h1, 16'h0007, "latch cleared");
    endtask
    task automatic t_prio;
        wr16(3'h0, 16'h0008);
        wr16(3'h2, 16'h0001);
        gi <= 1;
        pins(4);
        chk("general request", 1, irq);
        chk("general vector", 16'h0000, vec);
        r55 <= 1;
        r65 <= 1;
        r75 <= 1;
        pins(8);
        chk("vector", 16'h003C, vec);
        chk("request", 1, irq);
        wr16(3'h2, 16'h0004);
        r75 <= 0;
        pins(4);
        chk("after ack", 0, irq);
        rdc(3'h1, 16'h0030, "enable after ack");
        wr16(3'h2, 16'h0001);
        pins(4);
        chk("nested", 16'h0034, vec);
    endtask
    task automatic t_trap;
        wr16(3'h2, 16'h0002);
        trap <= 1;
        pins(8);
        chk("trap vector", 16'h0024, vec);
        wr16(3'h2, 16'h0001);
        wr16(3'h2, 16'h0004);
        rdc(3'h1, 16'h0038, "saved enable");
        rdc(3'h1, 16'h0030, "current enable");
        chk("trap held", 0, irq);
        trap <= 0;
        pins(4);
        trap <= 1;
        pins(8);
        chk("trap again", 1, irq);
        wr16(3'h2, 16'h0004);
        {gi, trap, r55, r65} <= 4'h0;
    endtask
    task automatic t_cyc(logic [5:0] t);
        logic [15:0] q;
        int k;
        wr16(3'h4, 16'h0056);
        wr16(3'h6, {10'h000, t});
        q = 16'h0001;
        for (k = 0; k < 40 && q[0] !== 1'b0; k++)
            rd16(3'h7, q);
        chk("cycle busy", 0, q[0]);
    endtask
    task automatic t_bus;
        t_cyc(6'h01);
        rdc(3'h5, 16'h00A5, "read byte");
        t_cyc(6'h02);
        t_cyc(6'h04);
        t_cyc(6'h05);
        t_cyc(6'h08);
        // Idle cycle picks up the released bus, so the port read must overwrite it
        t_cyc(6'h06);
        t_cyc(6'h13);
        rdc(3'h5, 16'h00A5, "port byte");
        hold <= 1;
        pins(8);
        chk("hold ack", 1, hack);
        chk("address float", 0, aoe);
        hold <= 0;
        pins(8);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #100us;
        errors++;
        results;
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        t_serial;
        t_latch;
        t_prio;
        t_trap;
        t_bus;
        results;
    end
endmodule // cibcc_top_tb
